// ==== testbench/aea_accumulator_test.sv ====
/*
 * Self-checking testbench for the apparent energy accumulator: register sequences with expected values.
 * Assumes the core model drives the register port and the design keeps its default full-scale parameter.
 */
`timescale 1ns/1ps
`include "aea_defines.svh"
module aea_accumulator_test;
	logic                    clk, rst_n, zero_cross, dfc_valid, no_load_active, energy_pulse_n, energy_irq;
	logic [23:0]             apparent_power, current_rms, rdata, v;
	logic [24:0]             dfc_word;
	aea_pkg::aea_bus_s       bus;
	aea_pkg::aea_pulse_cfg_s pulse_cfg;
	int                      n_mismatch, checks, pulses, gap;
	logic [23:0]             t_p[5] = '{24'h20_0000, 24'h20_0000, 24'h20_0000, 24'hE0_0000, 24'h00_0000};
	logic [23:0]             t_d[5] = '{24'h00_0000, 24'h00_0001, 24'h00_0002, 24'h00_0000, 24'h00_0000};
	logic [23:0]             t_e[5] = '{24'h00_000A, 24'h00_000A, 24'h00_0005, 24'hFF_FFF6, 24'h00_000A};

	aea_accumulator aea_accumulator_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.apparent_power(apparent_power), .current_rms(current_rms), .zero_cross(zero_cross),
		.dfc_word(dfc_word), .dfc_valid(dfc_valid), .no_load_active(no_load_active), .pulse_cfg(pulse_cfg),
		.energy_pulse_n(energy_pulse_n), .energy_irq(energy_irq));
	aea_core_model aea_core_model_inst (.clk(clk), .bus(bus), .rdata(rdata));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	always @(posedge clk) if (energy_pulse_n === 1'b0) pulses++;

	task automatic test_done;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		aea_core_model_inst.reg_write(a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		aea_core_model_inst.reg_read(a, v);
	endtask : rd

	task automatic set_in(input logic [23:0] p, input logic [23:0] r);
		@(posedge clk);
		apparent_power <= p;
		current_rms <= r;
	endtask : set_in

	task automatic zc_pulse;
		@(posedge clk);
		zero_cross <= 1'b1;
		@(posedge clk);
		zero_cross <= 1'b0;
	endtask : zc_pulse

	// Waits for the next update strobe and returns the cycles waited; ten cycles without one count a mismatch and end the test.
	task automatic tick_gap;
		gap = 0;
		do begin
			@(posedge clk);
			#1;
			gap++;
		end while (dfc_valid !== 1'b1 && gap < 10);
		if (gap >= 10) begin
			n_mismatch++;
			test_done();
		end
	endtask : tick_gap

	// Growth of the read-clear register over 400 cycles, which is 80 updates.
	task automatic meas(input string name, input logic [23:0] exp);
		rd(`AEA_OFF_ENERGY_RC);
		repeat (400) @(posedge clk);
		rd(`AEA_OFF_ENERGY_RC);
		checks++;
		if (v !== exp && v !== exp + 24'h00_0001 && v !== exp - 24'h00_0001) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, v);
		end
	endtask : meas

	initial begin
		rst_n = 1'b0;
		apparent_power = '0;
		current_rms = '0;
		zero_cross = 1'b0;
		n_mismatch = 0;
		checks = 0;
		pulses = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(`AEA_OFF_HALF_CYCLES);
		chk("half_cycle_count", 24'h00_FFFF, v);
		rd(8'h55);
		chk("unmapped", 24'h00_0000, v);
		wr(`AEA_OFF_ENERGY, 24'h12_3456);
		rd(`AEA_OFF_ENERGY);
		chk("apparent_energy", 24'h00_0000, v);
		wr(`AEA_OFF_P1_NUM, 24'h00_1234);
		wr(`AEA_OFF_P1_DEN, 24'h00_5678);
		wr(`AEA_OFF_P2_NUM, 24'h00_9ABC);
		wr(`AEA_OFF_P2_DEN, 24'h00_DEF0);
		wr(`AEA_OFF_PULSE_MODE, 24'h00_00C0);
		chk("pulse_cfg", {16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 8'hC0}, pulse_cfg);
		wr(`AEA_OFF_PULSE_MODE, 24'h00_0000);
		tick_gap();
		tick_gap();
		chk("update_spacing", 5, gap);
		set_in(24'h00_1000, 24'h00_0000);
		wr(`AEA_OFF_GAIN, 24'h00_07FF);
		repeat (3) tick_gap();
		chk("dfc_word", 25'h00_17FF, dfc_word);
		wr(`AEA_OFF_GAIN, 24'h00_0800);
		repeat (3) tick_gap();
		chk("dfc_word", 25'h00_0800, dfc_word);
		wr(`AEA_OFF_GAIN, 24'h00_0000);
		// The last row runs in ampere-hour mode with the power input at zero.
		for (int i = 0; i < 5; i++) begin
			wr(`AEA_OFF_PULSE_MODE, (i == 4) ? 24'h00_0008 : 24'h00_0000);
			wr(`AEA_OFF_DIVIDER, t_d[i]);
			set_in(t_p[i], (i == 4) ? 24'h20_0000 : 24'h00_0000);
			repeat (10) @(posedge clk);
			meas("apparent_energy_read_clear", t_e[i]);
		end
		chk("energy_pulse_seen", 1, pulses > 0);
		wr(`AEA_OFF_PULSE_MODE, 24'h00_0000);
		for (int c = 0; c < 4; c++) begin
			for (int h = 0; h < 2; h++) begin
				wr(`AEA_OFF_NO_LOAD, 24'(c << 4));
				set_in(h ? 24'h00_03E8 : 24'h00_0064, 24'h00_0000);
				repeat (3) tick_gap();
				chk("no_load_active", (c != 0 && h == 0), no_load_active);
				chk("dfc_word", (c != 0 && h == 0) ? 0 : (h ? 1000 : 100), dfc_word);
			end
		end
		wr(`AEA_OFF_PULSE_MODE, 24'h00_0008);
		set_in(24'h20_0000, 24'h00_0064);
		repeat (3) tick_gap();
		chk("dfc_word", 0, dfc_word);
		wr(`AEA_OFF_PULSE_MODE, 24'h00_0000);
		set_in(24'h00_0064, 24'h00_0000);
		repeat (3) tick_gap();
		rd(`AEA_OFF_IRQ_ST_LOW);
		chk("no_load_flag", 1, v[`AEA_BIT_NO_LOAD]);
		wr(`AEA_OFF_IRQ_EN_LOW, 24'h00_0004);
		chk("energy_irq", 1, energy_irq);
		set_in(24'h00_03E8, 24'h00_0000);
		repeat (3) tick_gap();
		chk("energy_irq", 1, energy_irq);
		wr(`AEA_OFF_IRQ_ST_LOW, 24'h00_0000);
		rd(`AEA_OFF_IRQ_ST_LOW);
		chk("no_load_flag", 0, v[`AEA_BIT_NO_LOAD]);
		chk("energy_irq", 0, energy_irq);
		wr(`AEA_OFF_NO_LOAD, 24'h00_0000);
		set_in(24'h20_0000, 24'h00_0000);
		wr(`AEA_OFF_HALF_CYCLES, 24'h00_0002);
		rd(`AEA_OFF_LINE_ENERGY);
		chk("line_apparent_energy", 0, v);
		zc_pulse();
		repeat (199) @(posedge clk);
		zc_pulse();
		rd(`AEA_OFF_IRQ_ST_HIGH);
		chk("cycle_end_flag", 0, v[`AEA_BIT_CYCLE_END]);
		repeat (195) @(posedge clk);
		zc_pulse();
		repeat (3) @(posedge clk);
		rd(`AEA_OFF_IRQ_ST_HIGH);
		chk("cycle_end_flag", 1, v[`AEA_BIT_CYCLE_END]);
		rd(`AEA_OFF_LINE_ENERGY);
		chk("line_energy_near", 1, v >= 24'h00_0009 && v <= 24'h00_000B);
		wr(`AEA_OFF_IRQ_EN_HIGH, 24'h00_0004);
		chk("energy_irq", 1, energy_irq);
		wr(`AEA_OFF_IRQ_ST_HIGH, 24'h00_0000);
		chk("energy_irq", 0, energy_irq);
		// A large negative sample drives the total below zero, so the unsigned register shows bit 23 set.
		set_in(24'h80_0000, 24'h00_0000);
		repeat (1000) @(posedge clk);
		rd(`AEA_OFF_IRQ_ST_MID);
		chk("energy_half_full", 1, v[`AEA_BIT_HALF_FULL]);
		wr(`AEA_OFF_IRQ_EN_MID, 24'h00_0004);
		chk("energy_irq", 1, energy_irq);
		test_done();
	end
endmodule : aea_accumulator_test

// ==== testbench/aea_core_model.sv ====
/*
 * Core-side register master for the apparent energy accumulator: write and read tasks on the plain register port.
 * Assumes one clock, read data registered one cycle after the read strobe, and a slave that never waits.
 */
`timescale 1ns/1ps
module aea_core_model (
	input  wire logic         clk,
	output aea_pkg::aea_bus_s bus,
	input  wire logic [23:0]  rdata
);
	initial begin
		bus = '0;
	end

	// Released address and data lines show the inverse, so a slave that samples late reads rubbish.
	task automatic reg_write(input logic [7:0] addr, input logic [23:0] data);
		@(posedge clk);
		bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
		// Return once the written register has settled, so a caller may compare at once.
		#1;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] addr, output logic [23:0] data);
		@(posedge clk);
		bus <= '{addr: addr, wdata: 24'h00_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '{addr: ~addr, wdata: 24'hFF_FFFF, wr: 1'b0, rd: 1'b0};
		#1;
		data = rdata;
	endtask : reg_read
endmodule : aea_core_model

// ==== verilog/aea_accumulator.sv ====
/*
 * Apparent energy accumulator: gain, no-load gate, 48-bit accumulation, divided, read-clear and line registers,
 * status flags and the sample word for the two frequency converters.
 * Assumes power, rms and zero-crossing inputs are synchronous to clk and that the bus master follows the strobe rules.
 */
// Function
// [R1] Accumulate each sample into 48-bit register.
// [R2] Update once every five clock periods.
// [R3] Accumulation uses signed addition.
// [R4] Divide by divider, zero means one.
// [R5] Read-clear energy copy returns zero after read.
// [R6] Unsigned energy; half-full, overflow flags enabled.
// [R7] Half-full judged on full 24 bits.
// [R8] Line accumulation always runs between zero crossings.
// [R9] Half-cycle count is unsigned 16 bits.
// [R10] Cycle end sets flag, enabled interrupt.
// [R11] Count write clears line, restarts at crossing.
// [R12] Line register uses same path and weight.
// [R13] Below threshold: no accumulation, no-load flag.
// [R14] Two-bit code selects no-load threshold.
// [R15] Same threshold gates the rms pulse.
// [R16] Ampere-hour bit selects current rms input.
// [R17] Same gain, divider, pulse registers apply.
// [R18] Pulse from gained signal, active low.
// [R19] No offset correction in this path.
// [R20] Two independent frequency converter channels fed.
// [R21] Gain is one plus gain over 4096.
// [R22] Writing zero clears a status bit.
// [R23] Energy wraps and flags overflow together.
`timescale 1ns/1ps
`include "aea_defines.svh"

module aea_accumulator #(
	parameter logic [23:0] FULL_SCALE = 24'h1A_36E2
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire aea_pkg::aea_bus_s     bus,
	output logic [23:0]                rdata,
	input  wire logic [23:0]           apparent_power,
	input  wire logic [23:0]           current_rms,
	input  wire logic                  zero_cross,
	output logic [24:0]                dfc_word,
	output logic                       dfc_valid,
	output logic                       no_load_active,
	output aea_pkg::aea_pulse_cfg_s    pulse_cfg,
	output logic                       energy_pulse_n,
	output logic                       energy_irq
);

	localparam logic [23:0] THR_01 = 24'((32'(FULL_SCALE) * 3) / 10000);
	localparam logic [23:0] THR_10 = 24'((32'(FULL_SCALE) * 3) / 20000);
	localparam logic [23:0] THR_11 = 24'((32'(FULL_SCALE) * 3) / 40000);

	logic [2:0]          tick_cnt_r;
	logic                tick;
	logic [7:0]          mode_r;
	logic [7:0]          nl_mode_r;
	logic [15:0]         half_cycles_r;
	logic [11:0]         gain_r;
	logic [7:0]          div_r;
	logic [15:0]         p1_num_r;
	logic [15:0]         p1_den_r;
	logic [15:0]         p2_num_r;
	logic [15:0]         p2_den_r;
	logic [7:0]          en_low_r;
	logic [7:0]          en_mid_r;
	logic [7:0]          en_high_r;
	logic [7:0]          st_low_r;
	logic [7:0]          st_mid_r;
	logic [7:0]          st_high_r;
	logic signed [47:0]  acc_r;
	logic signed [47:0]  line_acc_r;
	logic [23:0]         energy_r;
	logic [23:0]         energy_nxt;
	logic [23:0]         rc_base_r;
	logic [23:0]         line_energy_r;
	logic [15:0]         half_cnt_r;
	aea_pkg::aea_line_e  line_state_r;
	logic signed [23:0]  sel_word;
	logic signed [35:0]  gain_prod;
	logic signed [24:0]  scaled;
	logic [24:0]         magnitude;
	logic [23:0]         threshold;
	logic                below;
	logic                wr_count;
	logic                line_end;
	logic                half_full_evt;
	logic                overflow_evt;

	// The quotient treats the total as unsigned; a negative total divided by more than one is not meaningful.
	function automatic logic [23:0] div_upper(input logic [47:0] a, input logic [7:0] d);
		logic [47:0] q;
		q = a / 48'((d == 8'h00) ? 8'h01 : d);
		return q[47:24];
	endfunction : div_upper

	// Updates are spaced by a modulo-five counter instead of a clock enable.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 3'h0;
		end else if (tick_cnt_r == 3'(`AEA_SAMPLE_DIV - 1)) begin // [R2]
			tick_cnt_r <= 3'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 3'h1;
		end
	end
	assign tick = (tick_cnt_r == 3'h0);

	// The input word carries no offset term; offsets are removed upstream in the rms stages.
	always_comb begin
		sel_word  = mode_r[`AEA_BIT_AMP_HOUR] ? current_rms : apparent_power; // [R16] [R19]
		gain_prod = sel_word * $signed(gain_r);
		scaled    = 25'(sel_word) + 25'(gain_prod >>> 12); // [R21] [R17]
		magnitude = scaled[24] ? 25'(-scaled) : scaled;
		unique case (nl_mode_r[`AEA_BIT_NL_LSB +: 2]) // [R14]
			2'b01:   threshold = THR_01;
			2'b10:   threshold = THR_10;
			2'b11:   threshold = THR_11;
			default: threshold = 24'h00_0000;
		endcase
		below = (nl_mode_r[`AEA_BIT_NL_LSB +: 2] != 2'b00) && (magnitude < 25'(threshold));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= 48'sh0000_0000_0000;
		end else if (tick && !below) begin // [R13]
			acc_r <= acc_r + 48'(scaled); // [R1] [R3]
		end
	end

	assign energy_nxt    = div_upper(acc_r, div_r); // [R4]
	assign half_full_evt = energy_nxt[23] && !energy_r[23]; // [R6] [R7]
	assign overflow_evt  = energy_nxt < energy_r; // [R23]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			energy_r <= 24'h00_0000;
		end else begin
			energy_r <= energy_nxt; // [R1] [R23]
		end
	end

	// The read-clear copy is the distance from a snapshot, so no second divider is needed.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc_base_r <= 24'h00_0000;
		end else if (bus.rd && bus.addr == `AEA_OFF_ENERGY_RC) begin
			rc_base_r <= energy_r; // [R5]
		end
	end

	assign wr_count = bus.wr && bus.addr == `AEA_OFF_HALF_CYCLES;
	// A zero count is taken as one half cycle.
	assign line_end = (line_state_r == aea_pkg::AEA_LINE_RUN) && zero_cross &&
		(half_cnt_r + 16'h0001 >= half_cycles_r); // [R9]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_state_r <= aea_pkg::AEA_LINE_WAIT;
			half_cnt_r   <= 16'h0000;
			line_acc_r   <= 48'sh0000_0000_0000;
		end else if (wr_count) begin
			line_state_r <= aea_pkg::AEA_LINE_WAIT; // [R11]
			half_cnt_r   <= 16'h0000;
			line_acc_r   <= 48'sh0000_0000_0000;
		end else begin
			unique case (line_state_r)
				aea_pkg::AEA_LINE_WAIT: begin
					if (zero_cross) begin
						line_state_r <= aea_pkg::AEA_LINE_RUN; // [R8]
						half_cnt_r   <= 16'h0000;
						line_acc_r   <= 48'sh0000_0000_0000;
					end
				end
				aea_pkg::AEA_LINE_RUN: begin
					// The sample at the ending crossing is dropped so that adjacent periods never share one.
					if (line_end) begin
						half_cnt_r <= 16'h0000; // [R10]
						line_acc_r <= 48'sh0000_0000_0000;
					end else begin
						if (zero_cross) begin
							half_cnt_r <= half_cnt_r + 16'h0001; // [R9]
						end
						if (tick && !below) begin
							line_acc_r <= line_acc_r + 48'(scaled); // [R12]
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_energy_r <= 24'h00_0000;
		end else if (wr_count) begin
			line_energy_r <= 24'h00_0000; // [R11]
		end else if (line_end) begin
			line_energy_r <= div_upper(line_acc_r, div_r); // [R12]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r        <= `AEA_RST_BYTE;
			nl_mode_r     <= `AEA_RST_BYTE;
			half_cycles_r <= `AEA_RST_HALF_CYCLES;
			gain_r        <= `AEA_RST_GAIN;
			div_r         <= `AEA_RST_BYTE;
			p1_num_r      <= `AEA_RST_WORD16;
			p1_den_r      <= `AEA_RST_WORD16;
			p2_num_r      <= `AEA_RST_WORD16;
			p2_den_r      <= `AEA_RST_WORD16;
			en_low_r      <= `AEA_RST_BYTE;
			en_mid_r      <= `AEA_RST_BYTE;
			en_high_r     <= `AEA_RST_BYTE;
		end else if (bus.wr) begin
			// Writes to read-only or unmapped offsets fall through and change nothing.
			unique case (bus.addr)
				`AEA_OFF_PULSE_MODE:  mode_r        <= bus.wdata[7:0];
				`AEA_OFF_NO_LOAD:     nl_mode_r     <= bus.wdata[7:0];
				`AEA_OFF_HALF_CYCLES: half_cycles_r <= bus.wdata[15:0];
				`AEA_OFF_GAIN:        gain_r        <= bus.wdata[11:0];
				`AEA_OFF_DIVIDER:     div_r         <= bus.wdata[7:0];
				`AEA_OFF_P1_NUM:      p1_num_r      <= bus.wdata[15:0];
				`AEA_OFF_P1_DEN:      p1_den_r      <= bus.wdata[15:0];
				`AEA_OFF_P2_NUM:      p2_num_r      <= bus.wdata[15:0];
				`AEA_OFF_P2_DEN:      p2_den_r      <= bus.wdata[15:0];
				`AEA_OFF_IRQ_EN_LOW:  en_low_r      <= bus.wdata[7:0];
				`AEA_OFF_IRQ_EN_MID:  en_mid_r      <= bus.wdata[7:0];
				`AEA_OFF_IRQ_EN_HIGH: en_high_r     <= bus.wdata[7:0];
				default: ;
			endcase
		end
	end

	// Status bits clear on a written zero, but a same-cycle event wins over the clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_low_r  <= `AEA_RST_BYTE;
			st_mid_r  <= `AEA_RST_BYTE;
			st_high_r <= `AEA_RST_BYTE;
		end else begin
			st_low_r  <= ((bus.wr && bus.addr == `AEA_OFF_IRQ_ST_LOW)  ? st_low_r  & bus.wdata[7:0] : st_low_r)
				| (8'(tick && below) << `AEA_BIT_NO_LOAD); // [R22] [R13]
			st_mid_r  <= ((bus.wr && bus.addr == `AEA_OFF_IRQ_ST_MID)  ? st_mid_r  & bus.wdata[7:0] : st_mid_r)
				| (8'(half_full_evt) << `AEA_BIT_HALF_FULL) | (8'(overflow_evt) << `AEA_BIT_OVERFLOW); // [R6] [R23]
			st_high_r <= ((bus.wr && bus.addr == `AEA_OFF_IRQ_ST_HIGH) ? st_high_r & bus.wdata[7:0] : st_high_r)
				| (8'(line_end) << `AEA_BIT_CYCLE_END); // [R10]
		end
	end

	assign energy_irq = |(st_low_r & en_low_r) | |(st_mid_r & en_mid_r) | |(st_high_r & en_high_r); // [R6] [R10] [R13]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 24'h00_0000;
		end else if (bus.rd) begin
			// Narrow registers read back as zero above their width.
			unique case (bus.addr)
				`AEA_OFF_ENERGY:      rdata <= energy_r;
				`AEA_OFF_ENERGY_RC:   rdata <= energy_r - rc_base_r; // [R5]
				`AEA_OFF_LINE_ENERGY: rdata <= line_energy_r;
				`AEA_OFF_PULSE_MODE:  rdata <= {16'h0000, mode_r};
				`AEA_OFF_NO_LOAD:     rdata <= {16'h0000, nl_mode_r};
				`AEA_OFF_HALF_CYCLES: rdata <= {8'h00, half_cycles_r};
				`AEA_OFF_GAIN:        rdata <= {12'h000, gain_r};
				`AEA_OFF_DIVIDER:     rdata <= {16'h0000, div_r};
				`AEA_OFF_P1_NUM:      rdata <= {8'h00, p1_num_r};
				`AEA_OFF_P1_DEN:      rdata <= {8'h00, p1_den_r};
				`AEA_OFF_P2_NUM:      rdata <= {8'h00, p2_num_r};
				`AEA_OFF_P2_DEN:      rdata <= {8'h00, p2_den_r};
				`AEA_OFF_IRQ_EN_LOW:  rdata <= {16'h0000, en_low_r};
				`AEA_OFF_IRQ_EN_MID:  rdata <= {16'h0000, en_mid_r};
				`AEA_OFF_IRQ_EN_HIGH: rdata <= {16'h0000, en_high_r};
				`AEA_OFF_IRQ_ST_LOW:  rdata <= {16'h0000, st_low_r};
				`AEA_OFF_IRQ_ST_MID:  rdata <= {16'h0000, st_mid_r};
				`AEA_OFF_IRQ_ST_HIGH: rdata <= {16'h0000, st_high_r};
				default:              rdata <= 24'h00_0000;
			endcase
		end else begin
			rdata <= 24'h00_0000;
		end
	end

	// Both converter channels take the same gated word; each applies its own ratio from pulse_cfg.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dfc_word       <= 25'h000_0000;
			dfc_valid      <= 1'b0;
			no_load_active <= 1'b0;
		end else begin
			dfc_word       <= below ? 25'h000_0000 : scaled; // [R15] [R18] [R20]
			dfc_valid      <= tick;
			no_load_active <= below; // [R15]
		end
	end

	// Low for one clock whenever the energy LSB moves, so a lamp or counter sees an active-low strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			energy_pulse_n <= 1'b1;
		end else begin
			energy_pulse_n <= (energy_nxt == energy_r); // [R18]
		end
	end

	assign pulse_cfg = '{num1: p1_num_r, den1: p1_den_r, num2: p2_num_r, den2: p2_den_r, mode: mode_r}; // [R20]

	// All checks share the one clock domain, so a single default clocking serves them.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_tick_spacing: assert property (tick |=> !tick [*4] ##1 tick) // [R2]
		else $error("update spacing is not five clocks");
	a_acc_idle: assert property (!tick |=> acc_r == $past(acc_r)) // [R1]
		else $error("accumulator moved between updates");
	a_no_load_gate: assert property (tick && below |=> acc_r == $past(acc_r) && st_low_r[`AEA_BIT_NO_LOAD]) // [R13]
		else $error("no-load sample was accumulated or not flagged");
	a_acc_add: assert property (tick && !below |=> acc_r == $past(acc_r) + 48'($past(scaled))) // [R3]
		else $error("accumulator did not add the gained sample");
	a_cycle_end_flag: assert property (line_end && !wr_count |=> st_high_r[`AEA_BIT_CYCLE_END] && half_cnt_r == 16'h0000) // [R10]
		else $error("cycle end did not set flag or restart count");
	a_count_write: assert property (wr_count |=> line_energy_r == 24'h00_0000 && line_state_r == aea_pkg::AEA_LINE_WAIT) // [R11]
		else $error("count write did not clear line energy");
	a_rc_read: assert property (bus.rd && bus.addr == `AEA_OFF_ENERGY_RC |=> rc_base_r == $past(energy_r)) // [R5]
		else $error("read-clear copy not reset by read");
	a_overflow_wrap: assert property (overflow_evt |=> st_mid_r[`AEA_BIT_OVERFLOW]) // [R23]
		else $error("wrap did not flag overflow");
	a_half_full: assert property (half_full_evt |=> st_mid_r[`AEA_BIT_HALF_FULL] && energy_r[23]) // [R7]
		else $error("half-full not flagged on bit 23");
	a_irq_follow: assert property (st_high_r[`AEA_BIT_CYCLE_END] && en_high_r[`AEA_BIT_CYCLE_END] |-> energy_irq) // [R10]
		else $error("enabled cycle end without interrupt");

	// Configuration, gating, line-period, strobe and read checks; the scenarios reach only a few settings, so these watch every cycle.
	a_div_zero: assert property (div_r == 8'h00 |-> energy_nxt == acc_r[47:24]) // [R4]
		else $error("zero divider did not act as one");
	a_gain_unity: assert property (gain_r == 12'h000 |-> scaled == 25'(sel_word)) // [R21]
		else $error("zero gain changed the sample");
	a_amp_select: assert property (mode_r[`AEA_BIT_AMP_HOUR] && gain_r == 12'h000 |-> // [R16]
		scaled == 25'($signed(current_rms)))
		else $error("ampere-hour mode did not select current rms");
	a_no_load_off: assert property (nl_mode_r[`AEA_BIT_NL_LSB +: 2] == 2'b00 |-> !below) // [R14]
		else $error("no-load gate active while disabled");
	a_status_clear: assert property (bus.wr && bus.addr == `AEA_OFF_IRQ_ST_LOW && !bus.wdata[`AEA_BIT_NO_LOAD] && // [R22]
		!(tick && below) |=> !st_low_r[`AEA_BIT_NO_LOAD])
		else $error("written zero did not clear no-load flag");
	a_line_hold: assert property (!line_end && !wr_count |=> $stable(line_energy_r)) // [R8]
		else $error("line energy moved outside a period end");
	a_line_start: assert property (line_state_r == aea_pkg::AEA_LINE_WAIT && zero_cross && !wr_count |=> // [R11]
		line_state_r == aea_pkg::AEA_LINE_RUN && half_cnt_r == 16'h0000 && line_acc_r == 48'sh0000_0000_0000)
		else $error("crossing did not start a fresh period");
	a_half_count: assert property (line_state_r == aea_pkg::AEA_LINE_RUN && zero_cross && // [R9]
		!line_end && !wr_count |=> half_cnt_r == $past(half_cnt_r) + 16'h0001)
		else $error("half cycle was not counted");
	a_line_restart: assert property (line_end && !wr_count |=> // [R10]
		line_state_r == aea_pkg::AEA_LINE_RUN && line_acc_r == 48'sh0000_0000_0000)
		else $error("period end did not restart line accumulation");
	a_irq_quiet: assert property ((st_low_r & en_low_r) == 8'h00 && (st_mid_r & en_mid_r) == 8'h00 && // [R6]
		(st_high_r & en_high_r) == 8'h00 |-> !energy_irq)
		else $error("interrupt without an enabled status bit");
	a_dfc_gate: assert property (below |=> dfc_word == 25'h000_0000 && no_load_active) // [R15]
		else $error("converter word not gated below threshold");
	a_dfc_valid: assert property (tick |=> dfc_valid) // [R2]
		else $error("update without converter strobe");
	a_dfc_idle: assert property (!tick |=> !dfc_valid) // [R2]
		else $error("converter strobe between updates");
	a_pulse_low: assert property (energy_nxt != energy_r |=> !energy_pulse_n) // [R18]
		else $error("energy change without low pulse");
	a_div_write: assert property (bus.wr && bus.addr == `AEA_OFF_DIVIDER |=> div_r == $past(bus.wdata[7:0])) // [R17]
		else $error("divider write did not land");
	a_energy_read: assert property (bus.rd && bus.addr == `AEA_OFF_ENERGY |=> rdata == $past(energy_r)) // [R1]
		else $error("energy read returned a wrong value");

	c_cycle_end:  cover property (line_end);
	c_overflow:   cover property (overflow_evt);
	c_rc_read:    cover property (bus.rd && bus.addr == `AEA_OFF_ENERGY_RC ##1 rdata != 24'h00_0000);
	c_amp_hour:   cover property (tick && mode_r[`AEA_BIT_AMP_HOUR] && !below);
	c_no_load:    cover property (tick && below);

endmodule : aea_accumulator

// ==== verilog/aea_defines.svh ====
/*
 * Register offsets, field positions, reset values and timing counts for the apparent energy accumulator.
 * Assumes a byte-wide register address on the plain register port.
 */
`ifndef AEA_DEFINES_SVH
`define AEA_DEFINES_SVH

`define AEA_OFF_ENERGY       8'h07
`define AEA_OFF_ENERGY_RC    8'h08
`define AEA_OFF_LINE_ENERGY  8'h09
`define AEA_OFF_PULSE_MODE   8'h0C
`define AEA_OFF_NO_LOAD      8'h0E
`define AEA_OFF_HALF_CYCLES  8'h12
`define AEA_OFF_GAIN         8'h1F
`define AEA_OFF_DIVIDER      8'h26
`define AEA_OFF_P1_NUM       8'h27
`define AEA_OFF_P1_DEN       8'h28
`define AEA_OFF_P2_NUM       8'h29
`define AEA_OFF_P2_DEN       8'h2A
`define AEA_OFF_IRQ_EN_LOW   8'hD9
`define AEA_OFF_IRQ_EN_MID   8'hDA
`define AEA_OFF_IRQ_EN_HIGH  8'hDB
`define AEA_OFF_IRQ_ST_LOW   8'hDC
`define AEA_OFF_IRQ_ST_MID   8'hDD
`define AEA_OFF_IRQ_ST_HIGH  8'hDE

`define AEA_BIT_AMP_HOUR     3
`define AEA_BIT_NL_LSB       4
`define AEA_BIT_NO_LOAD      2
`define AEA_BIT_HALF_FULL    2
`define AEA_BIT_OVERFLOW     5
`define AEA_BIT_CYCLE_END    2

`define AEA_RST_BYTE         8'h00
`define AEA_RST_HALF_CYCLES  16'hFFFF
`define AEA_RST_WORD16       16'h0000
`define AEA_RST_GAIN         12'h000

`define AEA_SAMPLE_DIV       5

`endif

// ==== verilog/aea_pkg.sv ====
/*
 * Types shared by the apparent energy accumulator.
 * Assumes aea_defines.svh supplies the numeric constants.
 */
package aea_pkg;

	typedef enum logic [1:0] {
		AEA_LINE_WAIT = 2'b01,
		AEA_LINE_RUN  = 2'b10
	} aea_line_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [23:0] wdata;
		logic        wr;
		logic        rd;
	} aea_bus_s;

	typedef struct packed {
		logic [15:0] num1;
		logic [15:0] den1;
		logic [15:0] num2;
		logic [15:0] den2;
		logic [7:0]  mode;
	} aea_pulse_cfg_s;

endpackage : aea_pkg
